// ### logic/dsp_host.sv
`timescale 1ns/100ps
`default_nettype none
module dsp_host
    import seq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    dsp_link.host_end link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    logic [3:0] pins_req_q;
    logic [HALF_W-1:0] half_req_q, half_q, div_q;
    logic sample_rate_clock_q;
    logic load_q, bypass_q, clrdis_q;
    logic pd_q, rst_q, adc_q, dac_q;
    logic wr, rd_en;
    logic in_reset;

    assign wr = psel && penable && pwrite && clk_en;
    assign rd_en = psel && !penable && !pwrite;
    assign in_reset = !rst_q && !adc_q && !dac_q;

    // ==========================================================
    // APB registers written by software.
    // ==========================================================
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pins_req_q <= '0;
            half_req_q <= HALF_RESET;
            bypass_q <= 1'b0;
            clrdis_q <= 1'b0;
            load_q <= 1'b0;
        end else if (clk_en) begin
            load_q <= 1'b0;
            if (wr && paddr == PIN_CTRL_ADDR) begin
                pins_req_q <= pwdata[3:0];
                half_req_q <= pwdata[HALF_LSB +: HALF_W];
            end else if (wr && paddr == DEV_CFG_ADDR) begin
                bypass_q <= pwdata[HPF_BYPASS_BIT];
                clrdis_q <= pwdata[CLEAR_DISABLE_BIT];
                // A load is sent only while powered, in reset, with both
                // converter pins low.
                load_q <= pwdata[LOAD_BIT] && pd_q && in_reset;
            end
        end
    end

    // ==========================================================
    // Pin sequencing.
    // ==========================================================
    // All pins start low; converter pins move only while reset is low.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pd_q <= 1'b0;
            rst_q <= 1'b0;
            adc_q <= 1'b0;
            dac_q <= 1'b0;
        end else if (clk_en) begin
            pd_q <= pins_req_q[PD_BIT];
            rst_q <= pins_req_q[RST_BIT] && pd_q && !load_q;
            if (!rst_q) begin
                adc_q <= pins_req_q[ADC_PD_BIT];
                dac_q <= pins_req_q[DAC_PD_BIT];
            end
        end
    end

    // Sample clock divider; the rate is taken only in full reset hold.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            half_q <= HALF_RESET;
            div_q <= '0;
            sample_rate_clock_q <= 1'b0;
        end else if (clk_en) begin
            if (in_reset) begin
                half_q <= half_req_q;
            end
            if (div_q >= half_q - 1'b1) begin
                div_q <= '0;
                sample_rate_clock_q <= !sample_rate_clock_q;
            end else begin
                div_q <= div_q + 1'b1;
            end
        end
    end

    // Read data is registered in the setup cycle.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= '0;
        end else if (clk_en && rd_en) begin
            if (paddr == PIN_CTRL_ADDR) begin
                prdata <= {16'h0000, half_req_q, 4'h0, pins_req_q};
            end else if (paddr == DEV_CFG_ADDR) begin
                prdata <= {30'h0000_0000, clrdis_q, bypass_q};
            end else if (paddr == STATUS_ADDR) begin
                prdata <= {27'h000_0000, link.zero_detect_flag,
                           dac_q, adc_q, rst_q, pd_q};
            end else begin
                prdata <= '0;
            end
        end
    end

    assign pready = clk_en;
    assign pslverr = psel && penable && (paddr != PIN_CTRL_ADDR)
                     && (paddr != DEV_CFG_ADDR) && (paddr != STATUS_ADDR);

    assign link.power_down_n = pd_q;
    assign link.system_reset_n = rst_q;
    assign link.adc_powerdown_n = adc_q;
    assign link.dac_powerdown_n = dac_q;
    assign link.sample_rate_clock = sample_rate_clock_q;
    assign link.ctl_load = load_q;
    assign link.hpf_bypass_bit = bypass_q;
    assign link.clear_disable_bit = clrdis_q;
endmodule
`default_nettype wire

// ### logic/dsp_link.sv
`timescale 1ns/100ps
`default_nettype none
// Pins between the host and the audio DSP reset/clock sequencer.
interface dsp_link;
    logic power_down_n;
    logic system_reset_n;
    logic adc_powerdown_n;
    logic dac_powerdown_n;
    logic sample_rate_clock;
    logic ctl_load;
    logic hpf_bypass_bit;
    logic clear_disable_bit;
    logic zero_detect_flag;

    modport device_end (
        input power_down_n, system_reset_n, adc_powerdown_n,
        input dac_powerdown_n, sample_rate_clock, ctl_load,
        input hpf_bypass_bit, clear_disable_bit,
        output zero_detect_flag
    );
    modport host_end (
        output power_down_n, system_reset_n, adc_powerdown_n,
        output dac_powerdown_n, sample_rate_clock, ctl_load,
        output hpf_bypass_bit, clear_disable_bit,
        input zero_detect_flag
    );
endinterface
`default_nettype wire

// ### logic/dsp_sequencer.sv
// Summary of operation
// - DC block filter active unless bypass bit set
// - Zero flag rises after 8192 all-zero samples
// - Zero flag drops on first non-zero sample
// - Slave clocks supplied frequency-locked by outside party
// - Outside party never stops clocks while powered
// - Slave counter resets once after reset release
// - Clock frequency changes only during held reset
// - Realign timing when phase exceeds one sixteenth
// - Power-up holds power-down and reset low
// - Align to sample clock, start after four periods
// - Full power-down resets all, oscillator off
// - Reset keeps control register, RAMs writable
// - DAC after two periods, ADC zero 516 periods
// - Converter run state follows its pin table
// - Converter pins low for loads, change in reset
// - Clear delay memories 2260 periods after release
// - Data zero, flag high in reset and clear
// - Clear-disable bit skips the memory clearing
// - Full power-down restores control register defaults
// - Load control data in reset, then release
// - Filter and clear bits default to zero
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module dsp_sequencer
    import seq_pkg::*;
#(
    parameter int WIDTH = 20,
    parameter int PERIOD = CYCLES_PER_SAMPLE
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    dsp_link.device_end link,
    input wire logic slave_mode,
    input wire logic [WIDTH-1:0] adc_left,
    input wire logic [WIDTH-1:0] adc_right,
    input wire logic [WIDTH-1:0] dac_left,
    input wire logic [WIDTH-1:0] dac_right,
    output logic [WIDTH-1:0] dsp_in_left,
    output logic [WIDTH-1:0] dsp_in_right,
    output logic [WIDTH-1:0] dac_out_left,
    output logic [WIDTH-1:0] dac_out_right,
    output logic sample_tick,
    output logic adc_running,
    output logic dac_running,
    output logic oscillator_enable,
    output logic dsp_running,
    output logic clear_busy,
    output logic dsp_regs_reset,
    output logic program_ram_write_enable
);
    localparam int PW = $clog2(PERIOD);
    localparam logic [PW-1:0] LAST = PW'(PERIOD - 1);
    // The window scales with the frame length: one sixteenth of a period.
    localparam logic [PW-1:0] WIN = PW'(PERIOD / 16);
    localparam logic [11:0] CLEAR_LAST = 12'(CLEAR_PERIODS - 1);
    localparam logic [11:0] START_LAST = 12'(START_PERIODS - 1);
    localparam logic [9:0] ADC_INIT = 10'(ADC_INIT_PERIODS);
    localparam logic [9:0] DAC_LAT = 10'(DAC_LATENCY_PERIODS);
    localparam int AW = WIDTH + 4;

    seq_state_type state_q;
    logic hpf_bypass_q, clear_disable_q;
    logic sample_rate_clock_q;
    logic sample_rate_clock_rise;
    logic [PW-1:0] phase_q;
    logic phase_ok;
    logic [11:0] period_cnt_q;
    logic [9:0] adc_cnt_q, dac_cnt_q;
    logic full_off, held, zero_force;
    logic [WIDTH-1:0] filt [2];
    logic [WIDTH-1:0] zin [2];

    // Saturates a wide filter value into the sample width.
    function automatic logic [WIDTH-1:0] clamp(input logic signed [AW-1:0] v);
        logic signed [AW-1:0] hi, lo;
        hi = AW'($signed({1'b0, {(WIDTH-1){1'b1}}}));
        lo = ~hi;
        if (v > hi) begin
            clamp = hi[WIDTH-1:0];
        end else if (v < lo) begin
            clamp = lo[WIDTH-1:0];
        end else begin
            clamp = v[WIDTH-1:0];
        end
    endfunction

    assign full_off = !link.power_down_n;
    assign held = link.power_down_n && !link.system_reset_n;

    // ==========================================================
    // Frame timing.
    // ==========================================================
    // Sample clock pins are taken as synchronous; only the edge is needed.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sample_rate_clock_q <= 1'b0;
        end else if (clk_en) begin
            sample_rate_clock_q <= link.sample_rate_clock;
        end
    end
    assign sample_rate_clock_rise = link.sample_rate_clock && !sample_rate_clock_q;

    // Phase is the internal master counter; zero marks the frame start.
    assign phase_ok = (phase_q <= WIN) || (phase_q >= PW'(PERIOD) - WIN);

    // In slave mode the counter restarts on the first sample clock edge after release and
    // again only when the sample clock drifts out of the window.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= '0;
        end else if (clk_en) begin
            if (state_q == ST_ALIGN && slave_mode && sample_rate_clock_rise) begin
                phase_q <= '0;
            end else if (state_q > ST_ALIGN && slave_mode && sample_rate_clock_rise
                         && !phase_ok) begin
                phase_q <= '0;
            end else if (phase_q == LAST) begin
                phase_q <= '0;
            end else begin
                phase_q <= phase_q + 1'b1;
            end
        end
    end
    assign sample_tick = clk_en && (phase_q == LAST);

    // ==========================================================
    // Control register bits.
    // ==========================================================
    // Loads are taken only in held reset; full power-down restores defaults.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hpf_bypass_q <= 1'b0;
            clear_disable_q <= 1'b0;
        end else if (clk_en) begin
            if (full_off && !link.system_reset_n) begin
                hpf_bypass_q <= 1'b0;
                clear_disable_q <= 1'b0;
            end else if (held && link.ctl_load) begin
                hpf_bypass_q <= link.hpf_bypass_bit;
                clear_disable_q <= link.clear_disable_bit;
            end
        end
    end

    // ==========================================================
    // Reset sequencer.
    // ==========================================================
    // Release is taken at a master clock edge; the frame then aligns,
    // waits four periods, clears memory and runs.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_OFF;
            period_cnt_q <= '0;
        end else if (clk_en) begin
            if (full_off) begin
                state_q <= ST_OFF;
            end else if (!link.system_reset_n) begin
                state_q <= ST_HOLD;
                period_cnt_q <= '0;
            end else begin
                case (state_q)
                    ST_OFF, ST_HOLD: begin
                        state_q <= ST_ALIGN;
                    end
                    ST_ALIGN: begin
                        if (!slave_mode || sample_rate_clock_rise) begin
                            state_q <= ST_START;
                            period_cnt_q <= '0;
                        end
                    end
                    ST_START: begin
                        if (sample_tick && period_cnt_q == START_LAST) begin
                            period_cnt_q <= '0;
                            if (clear_disable_q) begin
                                state_q <= ST_RUN;
                            end else begin
                                state_q <= ST_CLEAR;
                            end
                        end else if (sample_tick) begin
                            period_cnt_q <= period_cnt_q + 1'b1;
                        end
                    end
                    ST_CLEAR: begin
                        if (sample_tick && period_cnt_q == CLEAR_LAST) begin
                            state_q <= ST_RUN;
                        end else if (sample_tick) begin
                            period_cnt_q <= period_cnt_q + 1'b1;
                        end
                    end
                    default: begin
                        state_q <= ST_RUN;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Converter run control and start-up latency.
    // ==========================================================
    // Run state follows the pin table; counts restart whenever held off.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            adc_running <= 1'b0;
            dac_running <= 1'b0;
        end else if (clk_en) begin
            adc_running <= link.power_down_n
                && (link.system_reset_n || link.adc_powerdown_n);
            dac_running <= link.power_down_n
                && (link.system_reset_n || link.dac_powerdown_n);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            adc_cnt_q <= '0;
            dac_cnt_q <= '0;
        end else if (clk_en) begin
            if (!adc_running) begin
                adc_cnt_q <= '0;
            end else if (sample_tick && adc_cnt_q != ADC_INIT) begin
                adc_cnt_q <= adc_cnt_q + 1'b1;
            end
            if (!dac_running) begin
                dac_cnt_q <= '0;
            end else if (sample_tick && dac_cnt_q != DAC_LAT) begin
                dac_cnt_q <= dac_cnt_q + 1'b1;
            end
        end
    end

    // ==========================================================
    // Sample path: DC block filter and zero forcing.
    // ==========================================================
    assign zero_force = (state_q != ST_RUN);

    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_ch
            logic signed [AW-1:0] x_prev_q, y_q, y_d, x_in;
            assign x_in = (ch == 0) ? AW'($signed(adc_left))
                                    : AW'($signed(adc_right));
            // y = x - x_prev + y_prev - y_prev / 8192.
            assign y_d = x_in - x_prev_q + y_q - (y_q >>> HPF_SHIFT);
            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    x_prev_q <= '0;
                    y_q <= '0;
                end else if (sample_tick) begin
                    x_prev_q <= x_in;
                    y_q <= y_d;
                end
            end
            // The bypass passes the converter word straight through.
            assign filt[ch] = hpf_bypass_q ? x_in[WIDTH-1:0]
                                           : clamp(y_q);
            // Input to the DSP reads zero while initialising or cleared.
            assign zin[ch] = (zero_force || adc_cnt_q != ADC_INIT)
                             ? '0 : filt[ch];
        end
    endgenerate

    // Data outputs are registered once per sample period.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dsp_in_left <= '0;
            dsp_in_right <= '0;
            dac_out_left <= '0;
            dac_out_right <= '0;
        end else if (sample_tick) begin
            dsp_in_left <= zin[0];
            dsp_in_right <= zin[1];
            if (zero_force || dac_cnt_q != DAC_LAT) begin
                dac_out_left <= '0;
                dac_out_right <= '0;
            end else begin
                dac_out_left <= dac_left;
                dac_out_right <= dac_right;
            end
        end
    end

    zero_run_detector #(
        .WIDTH(WIDTH),
        .THRESHOLD(ZERO_RUN_SAMPLES)
    ) u_zero (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .sample_tick(sample_tick),
        .left(zin[0]),
        .right(zin[1]),
        .force_high(zero_force),
        .flag(link.zero_detect_flag)
    );

    // Status levels of the sequencer.
    assign oscillator_enable = !(full_off && !link.system_reset_n);
    assign dsp_running = (state_q == ST_RUN);
    assign clear_busy = (state_q == ST_CLEAR);
    assign dsp_regs_reset = (state_q == ST_OFF) || (state_q == ST_HOLD);
    assign program_ram_write_enable = (state_q == ST_HOLD);
endmodule
`default_nettype wire

// ### logic/seq_pkg.sv
package seq_pkg;
    // ==========================================================
    // Sample timing, in master clock cycles and sample periods.
    // ==========================================================
    localparam int CYCLES_PER_SAMPLE = 256;
    localparam int PHASE_WINDOW = CYCLES_PER_SAMPLE / 16;
    localparam int START_PERIODS = 4;
    localparam int CLEAR_PERIODS = 2260;
    localparam int ADC_INIT_PERIODS = 516;
    localparam int DAC_LATENCY_PERIODS = 2;
    localparam int ZERO_RUN_SAMPLES = 8192;
    // Leak shift of the DC block filter: 1/8192 per sample is about 1 Hz
    // at 48 kHz.
    localparam int HPF_SHIFT = 13;

    // ==========================================================
    // Host register map (byte addresses) and fields.
    // ==========================================================
    localparam logic [7:0] PIN_CTRL_ADDR = 8'h00;
    localparam logic [7:0] DEV_CFG_ADDR = 8'h04;
    localparam logic [7:0] STATUS_ADDR = 8'h08;
    localparam int PD_BIT = 0;
    localparam int RST_BIT = 1;
    localparam int ADC_PD_BIT = 2;
    localparam int DAC_PD_BIT = 3;
    localparam int HALF_LSB = 8;
    localparam int HALF_W = 8;
    localparam int HPF_BYPASS_BIT = 0;
    localparam int CLEAR_DISABLE_BIT = 1;
    localparam int LOAD_BIT = 2;
    localparam int ZERO_FLAG_BIT = 4;
    localparam logic [HALF_W-1:0] HALF_RESET = 8'h80;

    // Sequencer states of the device end.
    typedef enum logic [2:0] {
        ST_OFF,
        ST_HOLD,
        ST_ALIGN,
        ST_START,
        ST_CLEAR,
        ST_RUN
    } seq_state_type;
endpackage

// ### logic/zero_run_detector.sv
`timescale 1ns/100ps
`default_nettype none
module zero_run_detector
    import seq_pkg::*;
#(
    parameter int WIDTH = 20,
    parameter int THRESHOLD = ZERO_RUN_SAMPLES
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic sample_tick,
    input wire logic [WIDTH-1:0] left,
    input wire logic [WIDTH-1:0] right,
    input wire logic force_high,
    output logic flag
);
    localparam int CW = $clog2(THRESHOLD + 1);
    localparam logic [CW-1:0] LIMIT = CW'(THRESHOLD);

    logic [CW-1:0] count_q;
    logic flag_q;
    logic nonzero;

    assign nonzero = (left != '0) || (right != '0);

    // ==========================================================
    // Consecutive zero sample counter.
    // ==========================================================
    // Restarts on any non-zero sample, holds at the limit.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= '0;
        end else if (clk_en && sample_tick) begin
            if (nonzero) begin
                count_q <= '0;
            end else if (count_q != LIMIT) begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    // The flag rises with the zero that completes the run and falls on the
    // first non-zero sample.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_q <= 1'b0;
        end else if (clk_en && sample_tick) begin
            if (nonzero) begin
                flag_q <= 1'b0;
            end else if (count_q >= LIMIT - 1'b1) begin
                flag_q <= 1'b1;
            end
        end
    end

    // Reset and memory clearing hold the flag high.
    assign flag = flag_q | force_high;
endmodule
`default_nettype wire

// ### verification/audio_dsp_reset_clock_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Bench driving the host over APB with both ends joined.
module audio_dsp_reset_clock_sequencer_tb
    import seq_pkg::*;
;
    localparam int W = 20;
    logic ref_clk, reset_n, clk_en, slave_mode, psel, penable, pwrite;
    logic pready, pslverr, err, tick_s, dsp_run, clr_busy, flag;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [W-1:0] adc_l, adc_r, dac_l, dac_r, in_l, out_l;
    int errors, check_count, zrun, n;
    dsp_link dsp_link_inst ();
    assign flag = dsp_link_inst.zero_detect_flag;
    dsp_host dsp_host_inst (.ref_clk(ref_clk), .reset_n(reset_n),
        .clk_en(clk_en), .link(dsp_link_inst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    dsp_sequencer #(.WIDTH(W), .PERIOD(4)) dsp_sequencer_inst (
        .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
        .link(dsp_link_inst), .slave_mode(slave_mode), .adc_left(adc_l),
        .adc_right(adc_r), .dac_left(dac_l), .dac_right(dac_r),
        .dsp_in_left(in_l), .dsp_in_right(), .dac_out_left(out_l),
        .dac_out_right(), .sample_tick(tick_s), .adc_running(),
        .dac_running(), .oscillator_enable(), .dsp_running(dsp_run),
        .clear_busy(clr_busy), .dsp_regs_reset(),
        .program_ram_write_enable());
    seq_checker seq_checker_inst (.ref_clk(ref_clk), .reset_n(reset_n),
        .power_down_n(dsp_link_inst.power_down_n),
        .system_reset_n(dsp_link_inst.system_reset_n),
        .adc_powerdown_n(dsp_link_inst.adc_powerdown_n),
        .dac_powerdown_n(dsp_link_inst.dac_powerdown_n),
        .sample_rate_clock(dsp_link_inst.sample_rate_clock),
        .ctl_load(dsp_link_inst.ctl_load), .zero_detect_flag(flag));
    // Compares one value and reports a mismatch.
    task chk(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task results;
        $display("Checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // One APB transfer, holding the request until pready.
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge ref_clk); k++; end
        while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (k >= 50) begin chk("pready", 0, 1); results(); end
    endtask
    // Waits for a number of sample ticks, each under a bound.
    task ticks(input int num);
        int k;
        repeat (num) begin
            k = 0;
            do begin @(posedge ref_clk); k++; end
            while (tick_s !== 1'b1 && k < 20);
            if (k >= 20) begin chk("tick", 0, 1); results(); end
        end
    endtask
    // Free-running 25 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Main sequence.
    initial begin
        reset_n = 0; clk_en = 1; slave_mode = 0; psel = 0; penable = 0;
        pwrite = 0; paddr = '0; pwdata = '0; adc_l = '0; adc_r = '0;
        dac_l = '0; dac_r = '0; errors = 0; check_count = 0;
        n = $urandom(18);
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        apb(0, STATUS_ADDR, 0); chk("status", rd, 32'h10);
        apb(0, PIN_CTRL_ADDR, 0); chk("pins", rd, 32'h8000);
        apb(0, 8'h0c, 0); chk("unmapped", {err, rd[30:0]}, 32'h80000000);
        apb(1, PIN_CTRL_ADDR, 32'h8001);
        apb(1, DEV_CFG_ADDR, 32'h7);
        apb(1, PIN_CTRL_ADDR, 32'h800d);
        apb(1, PIN_CTRL_ADDR, 32'h800f);
        n = 0;
        while (dsp_run !== 1'b1 && n < 9) begin ticks(1); #1; n++; end
        chk("start", n inside {[3:6]}, 1);
        ticks(1);
        dac_l <= W'($urandom); dac_r <= W'($urandom);
        adc_l <= W'($urandom) | 20'h1; adc_r <= W'($urandom);
        ticks(4); #1;
        chk("dac out", out_l, dac_l);
        ticks(486); #1;
        chk("adc init", in_l, 0);
        ticks(40); #1;
        chk("bypass", in_l, adc_l);
        zrun = 0;
        for (int t = 0; t < 11300; t++) begin
            ticks(1);
            adc_l <= (t == 3000) ? 20'h5 : 20'h0;
            adc_r <= 20'h0;
            zrun = (t == 3000) ? 0 : zrun + 1;
            #1;
            if ((zrun > 4 && zrun < 8190) || zrun > 8200)
                chk("zero flag", flag, zrun > 8200);
        end
        ticks(1);
        adc_l <= 20'h10000;
        ticks(3); #1;
        chk("flag drop", flag, 0);
        apb(1, PIN_CTRL_ADDR, 32'h8000);
        slave_mode <= 1'b1;
        apb(1, PIN_CTRL_ADDR, 32'h8001);
        apb(1, PIN_CTRL_ADDR, 32'h8003);
        n = 0;
        while (clr_busy !== 1'b1 && n < 120) begin ticks(1); #1; n++; end
        chk("clear data", in_l, 0);
        chk("clear flag", flag, 1);
        n = 0;
        while (clr_busy === 1'b1 && n < 3000) begin ticks(1); #1; n++; end
        chk("clear len", n, CLEAR_PERIODS);
        ticks(100); #1;
        chk("dc block", in_l === adc_l, 0);
        results();
    end
endmodule
`default_nettype wire

// ### verification/seq_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Pin checks on the link between host and device ends.
module seq_checker (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic power_down_n,
    input wire logic system_reset_n,
    input wire logic adc_powerdown_n,
    input wire logic dac_powerdown_n,
    input wire logic sample_rate_clock,
    input wire logic ctl_load,
    input wire logic zero_detect_flag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Reset pin held low, and reset pin released.
    sequence held_s; !system_reset_n [*2]; endsequence
    sequence release_s; !system_reset_n ##1 system_reset_n; endsequence
    load_qual_a: assert property (
        ctl_load |-> power_down_n && !system_reset_n && !adc_powerdown_n
        && !dac_powerdown_n) else $error("load outside held reset");
    load_pulse_a: assert property (ctl_load |=> !ctl_load)
        else $error("load pulse too long");
    adc_pin_a: assert property ($changed(adc_powerdown_n) |->
        !$past(system_reset_n)) else $error("adc pin moved in run");
    dac_pin_a: assert property ($changed(dac_powerdown_n) |->
        !$past(system_reset_n)) else $error("dac pin moved in run");
    rst_order_a: assert property (system_reset_n |->
        $past(power_down_n)) else $error("reset released without power");
    flag_hold_a: assert property (held_s |-> zero_detect_flag)
        else $error("zero flag low in reset");
    flag_start_a: assert property (release_s |->
        zero_detect_flag [*8]) else $error("zero flag low in start");
    sample_rate_clock_half_a: assert property ($changed(sample_rate_clock) |=>
        $stable(sample_rate_clock) [*7]) else $error("rate clock too fast");
endmodule
`default_nettype wire
